// File: hw/frame_access_decoder.sv
// Decoder that steers CPU data accesses onto the three peripheral frames and applies their access limits.
`timescale 1ns/100ps
`default_nettype none
`include "frame_decode_cfg.svh"

module frame_access_decoder (
  input wire logic clock,                            // System clock, 125 MHz.
  input wire logic rst_n,                            // Asynchronous reset, active low.
  input wire frame_decode_pkg::cpu_req_t cpu_req,    // Access from the CPU.
  input wire logic unlock_exec,                      // Pulse: write-unlock instruction executed.
  input wire logic relock_exec,                      // Pulse: write-relock instruction executed.
  input wire logic security_unlocked,                // Level: code security module is unlocked.
  input wire logic order_protect_en,                 // Level: block protection mode for frames 1 and 2.
  input wire logic [31:0] f0_rdata,                  // Read data from the memory bus, same cycle.
  input wire logic [31:0] f1_rdata,                  // Read data from the 32-bit peripheral bus.
  input wire logic f1_stretch,                       // Frame 1 peripheral extends the read cycle.
  input wire logic [15:0] f2_rdata,                  // Read data from the 16-bit peripheral bus.
  output logic cpu_ready,                            // Decoder can take a request this cycle.
  output logic cpu_done,                             // Pulse: access finished.
  output logic cpu_refused,                          // With cpu_done: access was dropped.
  output logic [31:0] cpu_rdata,                     // Read data, valid with cpu_done.
  output logic write_unlocked,                       // Current write-unlock state.
  output frame_decode_pkg::bus_req_t f0_req,         // Request on the CPU memory bus.
  output frame_decode_pkg::bus_req_t f1_req,         // Request on the 32-bit peripheral bus.
  output frame_decode_pkg::bus_req_t f2_req          // Request on the 16-bit peripheral bus.
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_GAP,
    ST_ISSUE,
    ST_WAIT
  } state_t;

  // True when a word address lies inside a {first, last} region.
  function automatic logic in_region(input logic [15:0] addr, input logic [31:0] rgn);
    in_region = (addr >= rgn[31:16]) && (addr <= rgn[15:0]);
  endfunction

  // Map a word address onto its frame and its protection class.
  function automatic frame_decode_pkg::region_t decode(input logic [15:0] addr);
    frame_decode_pkg::region_t r;
    r = '{frame: frame_decode_pkg::FRAME_NONE, guarded: 1'b0, secured: 1'b0, can_ctl: 1'b0};
    if (in_region(addr, `RGN_F0_EMU) || in_region(addr, `RGN_F0_SEC) || in_region(addr, `RGN_F0_VECTAB)) begin
      r.frame = frame_decode_pkg::FRAME_0;
      r.guarded = 1'b1;
    end else if (in_region(addr, `RGN_F0_FLASH)) begin
      r.frame = frame_decode_pkg::FRAME_0;
      r.guarded = 1'b1;
      r.secured = 1'b1;
    end else if (in_region(addr, `RGN_F0_ADCRES) || in_region(addr, `RGN_F0_TIMER)
                 || in_region(addr, `RGN_F0_INTVEC)) begin
      r.frame = frame_decode_pkg::FRAME_0;
    end else if (in_region(addr, `RGN_F1_CANA_CTL) || in_region(addr, `RGN_F1_CANB_CTL)) begin
      // The CAN block masks its own protected registers and bits from the unlocked flag.
      r.frame = frame_decode_pkg::FRAME_1;
      r.can_ctl = 1'b1;
    end else if (in_region(addr, `RGN_F1_CANA_MBX) || in_region(addr, `RGN_F1_CANB_MBX)
                 || in_region(addr, `RGN_F1_PWM) || in_region(addr, `RGN_F1_CAP)
                 || in_region(addr, `RGN_F1_QEP) || in_region(addr, `RGN_F1_GPIO_DAT)) begin
      // Mailboxes and GPIO data stay open; PWM windows guard a subset inside the unit.
      r.frame = frame_decode_pkg::FRAME_1;
    end else if (in_region(addr, `RGN_F1_GPIO_CTL) || in_region(addr, `RGN_F1_GPIO_INT)) begin
      r.frame = frame_decode_pkg::FRAME_1;
      r.guarded = 1'b1;
    end else if (in_region(addr, `RGN_F2_SYSCTL)) begin
      r.frame = frame_decode_pkg::FRAME_2;
      r.guarded = 1'b1;
    end else if (in_region(addr, `RGN_F2_SERA) || in_region(addr, `RGN_F2_XINT)
                 || in_region(addr, `RGN_F2_ADC) || in_region(addr, `RGN_F2_SERBCD)
                 || in_region(addr, `RGN_F2_SPID) || in_region(addr, `RGN_F2_I2C)) begin
      r.frame = frame_decode_pkg::FRAME_2;
    end
    decode = r;
  endfunction

  state_t state;
  frame_decode_pkg::cpu_req_t cur;
  frame_decode_pkg::region_t cur_rgn;
  logic cur_drop;
  logic [1:0] count;
  logic prev_f1_write;
  logic prev_f12_write;
  logic [15:0] prev_addr;

  // Decode of the incoming request, evaluated in the cycle it is offered.
  wire frame_decode_pkg::region_t in_rgn = decode(cpu_req.addr);
  wire take = cpu_ready && cpu_req.valid;
  wire in_f1 = (in_rgn.frame == frame_decode_pkg::FRAME_1);
  wire in_f2 = (in_rgn.frame == frame_decode_pkg::FRAME_2);
  wire in_f12 = in_f1 || in_f2;

  // Reasons to drop an access before it reaches any bus.
  wire bad_can_size = in_rgn.can_ctl && (!cpu_req.wide || cpu_req.addr[0]);
  wire bad_f2_size = in_f2 && cpu_req.wide;
  wire sec_locked = in_rgn.secured && !security_unlocked;
  wire wr_blocked = cpu_req.write && in_rgn.guarded && !write_unlocked;
  wire unmapped = (in_rgn.frame == frame_decode_pkg::FRAME_NONE);
  wire drop = bad_can_size || bad_f2_size || sec_locked || wr_blocked || unmapped;

  // Extra cycles in front of a frame 1/2 access to keep order and spacing.
  wire need_b2b_gap = prev_f1_write && in_f1 && cpu_req.write;
  wire need_align = order_protect_en && prev_f12_write && in_f12 && !cpu_req.write
                    && (cpu_req.addr != prev_addr);
  wire [1:0] gap_len = need_align ? `ORDER_ALIGN_GAP : `F1_WRITE_GAP;

  // Request fields as they will be driven once the access issues.
  wire frame_decode_pkg::bus_req_t issue_req = '{
    valid: 1'b1,
    write: cur.write,
    wide: cur.wide,
    addr: cur.addr,
    wdata: cur.wdata,
    unlocked: write_unlocked
  };
  wire cur_f0 = (cur_rgn.frame == frame_decode_pkg::FRAME_0);
  wire cur_f1 = (cur_rgn.frame == frame_decode_pkg::FRAME_1);
  wire cur_f2 = (cur_rgn.frame == frame_decode_pkg::FRAME_2);
  wire cur_slow_read = !cur.write && (cur_f1 || cur_f2) && !cur_drop;

  // Data handed back: narrow reads and frame 2 reads are zero extended, dropped reads read zero.
  wire [31:0] f0_data = cur.wide ? f0_rdata : {16'h0000, f0_rdata[15:0]};
  wire [31:0] f2_data = {16'h0000, f2_rdata};
  wire [31:0] f1_data = cur.wide ? f1_rdata : {16'h0000, f1_rdata[15:0]};
  wire [31:0] slow_data = cur_f1 ? f1_data : f2_data;
  wire last_wait = (count == 2'h0) && !(cur_f1 && f1_stretch);
  wire f0_issue = (state == ST_ISSUE) && cur_f0 && !cur_drop;

  // Unlock state: both instructions are single-cycle; if both arrive together the unlock wins.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      write_unlocked <= 1'b0;
    end else if (unlock_exec) begin
      write_unlocked <= 1'b1;
    end else if (relock_exec) begin
      write_unlocked <= 1'b0;
    end
  end

  // History used for spacing; an idle cycle breaks a back-to-back write pair.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_f1_write <= 1'b0;
      prev_f12_write <= 1'b0;
      prev_addr <= 16'h0000;
    end else if (take) begin
      prev_f1_write <= in_f1 && cpu_req.write && !drop;
      prev_f12_write <= in_f12 && cpu_req.write && !drop;
      prev_addr <= cpu_req.addr;
    end else if (state == ST_IDLE) begin
      prev_f1_write <= 1'b0;
      prev_f12_write <= 1'b0;
    end
  end

  // Access sequencer. Only one access is in flight, so the buses see accesses in program order.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cur <= '0;
      cur_rgn <= '{frame: frame_decode_pkg::FRAME_NONE, guarded: 1'b0, secured: 1'b0, can_ctl: 1'b0};
      cur_drop <= 1'b0;
      count <= 2'h0;
      cpu_ready <= 1'b1;
      cpu_done <= 1'b0;
      cpu_refused <= 1'b0;
      cpu_rdata <= 32'h0000_0000;
    end else begin
      cpu_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (take) begin
            cur <= cpu_req;
            cur_rgn <= in_rgn;
            cur_drop <= drop;
            cpu_ready <= 1'b0;
            cpu_refused <= 1'b0;
            count <= gap_len - 2'h1;
            state <= ((need_b2b_gap || need_align) && !drop) ? ST_GAP : ST_ISSUE;
          end
        end
        ST_GAP: begin
          if (count == 2'h0) begin
            state <= ST_ISSUE;
          end else begin
            count <= count - 2'h1;
          end
        end
        ST_ISSUE: begin
          if (cur_slow_read) begin
            count <= `F12_READ_WAIT - 2'h1;
            state <= ST_WAIT;
          end else begin
            // Writes, frame 0 and dropped accesses end here with no stall.
            cpu_done <= 1'b1;
            cpu_ready <= 1'b1;
            cpu_refused <= cur_drop;
            cpu_rdata <= (f0_issue && !cur.write) ? f0_data : 32'h0000_0000;
            state <= ST_IDLE;
          end
        end
        ST_WAIT: begin
          if (last_wait) begin
            cpu_done <= 1'b1;
            cpu_ready <= 1'b1;
            cpu_rdata <= slow_data;
            state <= ST_IDLE;
          end else if (count != 2'h0) begin
            count <= count - 2'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
          cpu_ready <= 1'b1;
        end
      endcase
    end
  end

  // Next bus requests: the strobe stands through issue and any read wait cycles.
  // The drop flag of the held access must not gate a fresh take, since it still belongs to the previous access.
  wire next_active = ((state == ST_GAP && count == 2'h0) || (state == ST_IDLE && take && !drop
                     && !need_b2b_gap && !need_align) || (state == ST_ISSUE && cur_slow_read)
                     || (state == ST_WAIT && !last_wait));
  wire frame_decode_pkg::region_t next_rgn = (state == ST_IDLE) ? in_rgn : cur_rgn;
  wire frame_decode_pkg::bus_req_t fresh_req = '{
    valid: 1'b1,
    write: cpu_req.write,
    wide: cpu_req.wide,
    addr: cpu_req.addr,
    wdata: cpu_req.wdata,
    unlocked: write_unlocked
  };
  wire frame_decode_pkg::bus_req_t next_req = (state == ST_IDLE) ? fresh_req : issue_req;
  wire frame_decode_pkg::bus_req_t idle_req = '0;
  wire frame_decode_pkg::bus_req_t next_f0 =
    (next_active && next_rgn.frame == frame_decode_pkg::FRAME_0) ? next_req : idle_req;
  wire frame_decode_pkg::bus_req_t next_f1 =
    (next_active && next_rgn.frame == frame_decode_pkg::FRAME_1) ? next_req : idle_req;
  wire frame_decode_pkg::bus_req_t next_f2 =
    (next_active && next_rgn.frame == frame_decode_pkg::FRAME_2) ? next_req : idle_req;

  // Registered bus ports; a dropped access never raises any strobe, so its target is untouched.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      f0_req <= '0;
      f1_req <= '0;
      f2_req <= '0;
    end else begin
      f0_req <= next_f0;
      f1_req <= next_f1;
      f2_req <= next_f2;
    end
  end

endmodule
`default_nettype wire

// File: hw/frame_decode_cfg.svh
// Address map, wait-state counts and inserted gap lengths for the peripheral frame access decoder.
`ifndef FRAME_DECODE_CFG_SVH
`define FRAME_DECODE_CFG_SVH

// Each region is {first word, last word} of the 16-bit word address space.
`define RGN_F0_EMU 32'h0880_09FF
`define RGN_F0_FLASH 32'h0A80_0ADF
`define RGN_F0_SEC 32'h0AE0_0AEF
`define RGN_F0_ADCRES 32'h0B00_0B0F
`define RGN_F0_TIMER 32'h0C00_0C3F
`define RGN_F0_INTVEC 32'h0CE0_0CFF
`define RGN_F0_VECTAB 32'h0D00_0DFF
`define RGN_F1_CANA_CTL 32'h6000_60FF
`define RGN_F1_CANA_MBX 32'h6100_61FF
`define RGN_F1_CANB_CTL 32'h6200_62FF
`define RGN_F1_CANB_MBX 32'h6300_63FF
`define RGN_F1_PWM 32'h6800_697F
`define RGN_F1_CAP 32'h6A00_6A7F
`define RGN_F1_QEP 32'h6B00_6B7F
`define RGN_F1_GPIO_CTL 32'h6F80_6FBF
`define RGN_F1_GPIO_DAT 32'h6FC0_6FDF
`define RGN_F1_GPIO_INT 32'h6FE0_6FFF
`define RGN_F2_SYSCTL 32'h7010_702F
`define RGN_F2_SERA 32'h7040_705F
`define RGN_F2_XINT 32'h7070_707F
`define RGN_F2_ADC 32'h7100_711F
`define RGN_F2_SERBCD 32'h7740_776F
`define RGN_F2_SPID 32'h7780_778F
`define RGN_F2_I2C 32'h7900_792F

// Wait states and inserted cycles.
`define F12_READ_WAIT 2'h2
`define F1_WRITE_GAP 2'h1
`define ORDER_ALIGN_GAP 2'h1

`endif

// File: hw/frame_decode_pkg.sv
// Types shared by the peripheral frame access decoder and its users.
package frame_decode_pkg;

  // Which bus an address belongs to.
  typedef enum logic [1:0] {
    FRAME_NONE,
    FRAME_0,
    FRAME_1,
    FRAME_2
  } frame_sel_t;

  // Result of decoding one word address.
  typedef struct packed {
    frame_sel_t frame;
    logic guarded;   // Whole window needs the write-unlock state.
    logic secured;   // Window is also behind the code security module.
    logic can_ctl;   // CAN control window: 32-bit even accesses only.
  } region_t;

  // One access as the CPU issues it.
  typedef struct packed {
    logic valid;
    logic write;
    logic wide;      // 1 for a 32-bit access, 0 for 16-bit.
    logic [15:0] addr;
    logic [31:0] wdata;
  } cpu_req_t;

  // One access as it leaves on a downstream bus.
  typedef struct packed {
    logic valid;
    logic write;
    logic wide;
    logic [15:0] addr;
    logic [31:0] wdata;
    logic unlocked;  // Lets the peripheral guard its own protected bits.
  } bus_req_t;

endpackage

// File: bench/frame_decode_chk.sv
// Concurrent checks on the ports of the peripheral frame access decoder.
`timescale 1ns/100ps
`default_nettype none
module frame_decode_chk (
  input wire logic clock, // System clock.
  input wire logic rst_n, // Reset, active low.
  input wire frame_decode_pkg::cpu_req_t cpu_req, // CPU access.
  input wire logic unlock_exec, // Unlock pulse.
  input wire logic relock_exec, // Relock pulse.
  input wire logic security_unlocked, // Security state.
  input wire logic [31:0] f0_rdata, // Memory bus read data.
  input wire logic cpu_ready, // Take allowed.
  input wire logic cpu_done, // Access finished.
  input wire logic cpu_refused, // Access dropped.
  input wire logic [31:0] cpu_rdata, // Read data.
  input wire logic write_unlocked, // Unlock state.
  input wire frame_decode_pkg::bus_req_t f0_req, // Memory bus request.
  input wire frame_decode_pkg::bus_req_t f1_req, // 32-bit bus request.
  input wire frame_decode_pkg::bus_req_t f2_req // 16-bit bus request.
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // An access is taken when the decoder is ready and the CPU offers one.
  wire logic take = cpu_ready && cpu_req.valid;
  sequence refused_end;
    cpu_done && cpu_refused;
  endsequence
  sequence guarded_wr;
    take && cpu_req.write && !write_unlocked && cpu_req.addr inside {[16'h6F80:16'h6FBF]};
  endsequence
  sequence flash_locked;
    take && !security_unlocked && cpu_req.addr inside {[16'h0A80:16'h0ADF]};
  endsequence
  unlock_state_a: assert property (unlock_exec |=> write_unlocked)
    else $error("unlock pulse did not set the unlock state");
  relock_state_a: assert property (relock_exec && !unlock_exec |=> !write_unlocked)
    else $error("relock pulse did not clear the unlock state");
  guard_write_a: assert property (guarded_wr |-> ##1 !f1_req.valid ##[1:2] refused_end)
    else $error("locked write to a guarded window was not dropped");
  flash_gate_a: assert property (flash_locked |-> ##1 !f0_req.valid ##[1:2] refused_end)
    else $error("flash window reached while security locked");
  can_width_a: assert property (f1_req.valid && f1_req.addr[15:10] == 6'h18 && !f1_req.addr[8]
    |-> f1_req.wide && !f1_req.addr[0]) else $error("bad width or alignment in CAN control window");
  f1_route_a: assert property (f1_req.valid |-> f1_req.addr[15:12] == 4'h6 && !f0_req.valid && !f2_req.valid)
    else $error("frame 1 bus carries a foreign address");
  f2_narrow_a: assert property (f2_req.valid |-> !f2_req.wide && f2_req.addr[15:12] == 4'h7)
    else $error("frame 2 bus carries a wide or foreign access");
  f2_read_a: assert property ($rose(f2_req.valid) && !f2_req.write
    |-> f2_req.valid [*3] ##1 (cpu_done && !f2_req.valid)) else $error("frame 2 read wait count wrong");
  f1_write_a: assert property (f1_req.valid && f1_req.write |=> cpu_done && !f1_req.valid)
    else $error("frame 1 write not finished with zero wait");
  f0_read_a: assert property (f0_req.valid && !f0_req.write |=> cpu_done && cpu_rdata[15:0] == $past(f0_rdata[15:0]))
    else $error("frame 0 read data not returned");
endmodule
bind frame_access_decoder frame_decode_chk i_chk (.clock, .rst_n, .cpu_req, .unlock_exec, .relock_exec,
  .security_unlocked, .f0_rdata, .cpu_ready, .cpu_done, .cpu_refused, .cpu_rdata, .write_unlocked,
  .f0_req, .f1_req, .f2_req);
`default_nettype wire

// File: bench/periph_model.sv
// Behavioural model of the peripheral buses behind the decoder.
`timescale 1ns/100ps
`default_nettype none
module periph_model (
  input wire logic clock, // System clock.
  input wire logic rst_n, // Reset, active low.
  input wire frame_decode_pkg::bus_req_t f0_req, // Memory bus request.
  input wire frame_decode_pkg::bus_req_t f1_req, // 32-bit bus request.
  input wire frame_decode_pkg::bus_req_t f2_req, // 16-bit bus request.
  input wire logic [3:0] stretch_len, // Extra frame 1 read cycles.
  output logic [31:0] f0_rdata, // Memory bus read data.
  output logic [31:0] f1_rdata, // 32-bit bus read data.
  output logic [15:0] f2_rdata, // 16-bit bus read data.
  output logic f1_stretch // Frame 1 read extension.
);
  logic [15:0] churn;
  logic [3:0] waited;
  // Unselected buses show a changing pattern so stale data can never look right.
  assign f0_rdata = f0_req.valid ? {~f0_req.addr, f0_req.addr} : {churn, ~churn};
  assign f1_rdata = f1_req.valid ? {~f1_req.addr, f1_req.addr} : {~churn, churn};
  assign f2_rdata = f2_req.valid ? f2_req.addr ^ 16'h5A5A : churn;
  // Stretch starts in the second of the two fixed wait cycles, once the read has stood for two cycles, then lasts stretch_len cycles.
  assign f1_stretch = f1_req.valid && !f1_req.write && waited >= 4'h2 && waited < stretch_len + 4'h2;
  // The count restarts with every new frame 1 read.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      churn <= 16'h0000;
      waited <= 4'h0;
    end else begin
      churn <= churn + 16'h0001;
      waited <= (f1_req.valid && !f1_req.write) ? waited + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// File: bench/testbench.sv
// Self-checking testbench for the peripheral frame access decoder.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam frame_decode_pkg::frame_sel_t dropped = frame_decode_pkg::FRAME_NONE;
  localparam frame_decode_pkg::frame_sel_t on_f0 = frame_decode_pkg::FRAME_0;
  localparam frame_decode_pkg::frame_sel_t on_f1 = frame_decode_pkg::FRAME_1;
  localparam frame_decode_pkg::frame_sel_t on_f2 = frame_decode_pkg::FRAME_2;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  frame_decode_pkg::cpu_req_t cpu_req = '0;
  logic unlock_exec = 1'b0;
  logic relock_exec = 1'b0;
  logic security_unlocked = 1'b0;
  logic order_protect_en = 1'b0;
  logic [3:0] stretch_len = 4'h0;
  logic [31:0] f0_rdata, f1_rdata, cpu_rdata;
  logic [15:0] f2_rdata;
  logic f1_stretch, cpu_ready, cpu_done, cpu_refused, write_unlocked;
  frame_decode_pkg::bus_req_t f0_req, f1_req, f2_req, seen;
  frame_decode_pkg::frame_sel_t seen_frame;
  int miscompares = 0;
  int n_checks = 0;
  int lat;
  always #4 clock = ~clock;
  frame_access_decoder i_dut (.clock, .rst_n, .cpu_req, .unlock_exec, .relock_exec, .security_unlocked,
    .order_protect_en, .f0_rdata, .f1_rdata, .f1_stretch, .f2_rdata, .cpu_ready, .cpu_done, .cpu_refused,
    .cpu_rdata, .write_unlocked, .f0_req, .f1_req, .f2_req);
  periph_model i_model (.clock, .rst_n, .f0_req, .f1_req, .f2_req, .stretch_len, .f0_rdata, .f1_rdata,
    .f2_rdata, .f1_stretch);
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string what);
    n_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask
  // One access; returns just after the finishing edge, so calls chain with no idle cycle between.
  task automatic access(input logic wr, input logic wide, input logic [15:0] a, input logic [31:0] d,
      input frame_decode_pkg::frame_sel_t fr, input int le);
    logic [31:0] exp;
    exp = (wr || fr == dropped) ? 32'h0000_0000 : fr == on_f2 ? {16'h0000, a ^ 16'h5A5A} :
      wide ? {~a, a} : {16'h0000, a};
    chk(cpu_ready, "not ready for a new access");
    cpu_req = '{1'b1, wr, wide, a, d};
    seen = '0;
    seen_frame = dropped;
    @(posedge clock);
    #1;
    cpu_req.valid = 1'b0;
    for (lat = 1; cpu_done !== 1'b1; lat++) begin
      if (f0_req.valid === 1'b1) seen_frame = on_f0;
      if (f1_req.valid === 1'b1) seen_frame = on_f1;
      if (f2_req.valid === 1'b1) seen_frame = on_f2;
      seen = seen | f0_req | f1_req | f2_req;
      if (lat > 20) begin
        miscompares++;
        end_of_test();
      end
      @(posedge clock);
      #1;
    end
    chk(seen_frame === fr, "access went to the wrong bus");
    chk(cpu_refused === (fr == dropped), "refused flag wrong");
    chk(cpu_rdata === exp, "read data wrong");
    if (wr && fr != dropped) chk(seen.wdata[15:0] === d[15:0] && (!wide || seen.wdata === d), "write data");
    if (le != 0) chk(lat == le, "done latency wrong");
  endtask
  // Pulses the unlock (high) or relock (low) instruction for one cycle.
  task automatic instr(input logic un);
    unlock_exec = un;
    relock_exec = !un;
    @(posedge clock);
    #1;
    unlock_exec = 1'b0;
    relock_exec = 1'b0;
    chk(write_unlocked === un, "unlock state wrong");
  endtask
  task automatic test_frame0();
    access(1'b1, 1'b1, 16'h0C00, 32'hA5A5_1234, on_f0, 2);
    access(1'b0, 1'b1, 16'h0C02, 32'h0000_0000, on_f0, 2);
    access(1'b0, 1'b0, 16'h0B0F, 32'h0000_0000, on_f0, 2);
    access(1'b0, 1'b0, 16'h0880, 32'h0000_0000, on_f0, 2);
    access(1'b1, 1'b0, 16'h0880, 32'h0000_5555, dropped, 2);
    access(1'b1, 1'b0, 16'h0A00, 32'h0000_0001, dropped, 2);
    $display("test frame0 done");
  endtask
  task automatic test_unlock();
    instr(1'b1);
    access(1'b1, 1'b0, 16'h0D00, 32'h0000_1111, on_f0, 2);
    access(1'b1, 1'b0, 16'h7010, 32'h0000_2222, on_f2, 2);
    access(1'b1, 1'b1, 16'h6F80, 32'h1234_5678, on_f1, 0);
    instr(1'b0);
    access(1'b1, 1'b1, 16'h6FE0, 32'h0000_3333, dropped, 0);
    access(1'b1, 1'b1, 16'h6F80, 32'h0000_4444, dropped, 0);
    access(1'b1, 1'b0, 16'h6FC0, 32'h0000_00FF, on_f1, 0);
    $display("test unlock done");
  endtask
  task automatic test_flash();
    instr(1'b1);
    access(1'b0, 1'b0, 16'h0A80, 32'h0000_0000, dropped, 2);
    access(1'b1, 1'b0, 16'h0ADF, 32'h0000_0007, dropped, 2);
    security_unlocked = 1'b1;
    access(1'b1, 1'b0, 16'h0A80, 32'h0000_0009, on_f0, 2);
    instr(1'b0);
    access(1'b1, 1'b0, 16'h0A82, 32'h0000_000A, dropped, 2);
    access(1'b0, 1'b0, 16'h0AE0, 32'h0000_0000, on_f0, 2);
    $display("test flash done");
  endtask
  task automatic test_can();
    access(1'b1, 1'b1, 16'h6000, 32'hCAFE_0001, on_f1, 2);
    chk(seen.unlocked === 1'b0, "unlock flag downstream");
    access(1'b1, 1'b0, 16'h6004, 32'h0000_0002, dropped, 0);
    access(1'b0, 1'b1, 16'h6203, 32'h0000_0000, dropped, 0);
    access(1'b0, 1'b1, 16'h6202, 32'h0000_0000, on_f1, 4);
    access(1'b1, 1'b0, 16'h6101, 32'h0000_0BEE, on_f1, 0);
    access(1'b1, 1'b1, 16'h6302, 32'h0BAD_F00D, on_f1, 0);
    access(1'b1, 1'b0, 16'h697F, 32'h0000_0C0C, on_f1, 0);
    chk(seen.unlocked === 1'b0, "unlock flag downstream");
    instr(1'b1);
    access(1'b1, 1'b0, 16'h6800, 32'h0000_0D0D, on_f1, 0);
    chk(seen.unlocked === 1'b1, "unlock flag downstream");
    instr(1'b0);
    $display("test can pwm done");
  endtask
  task automatic test_frame2();
    access(1'b0, 1'b0, 16'h7040, 32'h0000_0000, on_f2, 4);
    access(1'b0, 1'b0, 16'h792F, 32'h0000_0000, on_f2, 4);
    access(1'b0, 1'b1, 16'h7100, 32'h0000_0000, dropped, 2);
    access(1'b1, 1'b1, 16'h7780, 32'h1111_2222, dropped, 2);
    access(1'b1, 1'b0, 16'h7030, 32'h0000_0003, dropped, 2);
    access(1'b1, 1'b0, 16'h7750, 32'h0000_0004, on_f2, 2);
    $display("test frame2 done");
  endtask
  task automatic test_timing();
    @(posedge clock);
    #1;
    access(1'b1, 1'b0, 16'h6A00, 32'h0000_0010, on_f1, 2);
    access(1'b1, 1'b0, 16'h6A02, 32'h0000_0011, on_f1, 3);
    order_protect_en = 1'b1;
    access(1'b0, 1'b0, 16'h6A04, 32'h0000_0000, on_f1, 5);
    access(1'b1, 1'b0, 16'h7040, 32'h0000_0012, on_f2, 2);
    access(1'b0, 1'b0, 16'h7041, 32'h0000_0000, on_f2, 5);
    order_protect_en = 1'b0;
    stretch_len = 4'h2;
    access(1'b0, 1'b1, 16'h6B00, 32'h0000_0000, on_f1, 6);
    stretch_len = 4'h0;
    $display("test timing done");
  endtask
  initial begin
    repeat (10) @(posedge clock);
    #1;
    rst_n = 1'b1;
    test_frame0();
    test_unlock();
    test_flash();
    test_can();
    test_frame2();
    test_timing();
    end_of_test();
  end
endmodule
`default_nettype wire
